// file: design/lpi_top.sv
`include "lpi_defines.svh"
`default_nettype none
module lpi_top (
    input wire logic I_CLK,
    input wire logic I_RST,
    input wire logic I_POWER_ON_PRESET_PULSE,
    input wire logic I_CONTROL_RESET_LINE,
    input wire logic I_FLAG_ENABLE_PULSE,
    input wire logic I_INTERRUPT_ACKNOWLEDGE,
    input wire logic I_SERVICE_REQUEST_STROBE,
    input wire logic I_SELECT_MATCH_UPPER,
    input wire logic I_SELECT_MATCH_LOWER,
    input wire logic I_IO_INSTRUCTION_QUALIFIER,
    input wire logic I_SET_FLAG_INSTR,
    input wire logic I_CLEAR_FLAG_INSTR,
    input wire logic I_SET_CONTROL_INSTR,
    input wire logic I_CLEAR_CONTROL_INSTR,
    input wire logic I_GLOBAL_INTERRUPT_ENABLE,
    input wire logic I_PRIORITY_IN_HIGH,
    input wire logic I_IO_OUTPUT_STROBE,
    input wire logic I_IO_INPUT_STROBE,
    input wire logic I_SKIP_IF_FLAG_SET,
    input wire logic I_SKIP_IF_FLAG_CLEAR,
    input wire logic [15:0] I_OUTPUT_BUS,
    input wire logic I_ACCEPT,
    input wire logic I_LINE_READY,
    input wire logic I_READY,
    input wire logic I_PAPER_OUT,
    output logic O_PRIORITY_OUT_LOW,
    output logic O_FLAG_LINE_OUT,
    output logic O_INTERRUPT_REQUEST_OUT,
    output logic O_SKIP_FLAG_LINE,
    output logic [15:0] O_INPUT_DATA_BUS,
    output logic O_OUTPUT_WRITE_READY,
    output logic [6:0] O_PRINT_DATA,
    output logic O_CONTROL_BIT,
    output logic O_DATA_READY,
    output logic O_MASTER_CLEAR
);
    // all block state in one struct
    typedef struct packed {
        logic flag;
        logic flag_buf;
        logic ctrl;
        logic strobe;
        logic irq;
        logic hs_in_q;
        logic crs_q;
        lpi_pkg::lpi_hs_t hs_ph;
        logic [3:0] hs_cnt;
        logic [9:0] mclr_cnt;
        logic [15:0] status;
        lpi_pkg::lpi_word_t out_w;
        logic loaded;
    } lpi_state_t;

    lpi_state_t s_q;
    lpi_state_t s_d;

    logic sel;
    logic hs_in;
    logic ien_ok;
    logic ack_p;
    logic cmpl_p;
    logic fifo_ready;
    logic fifo_valid;
    lpi_pkg::lpi_word_t fifo_in;
    lpi_pkg::lpi_word_t fifo_out;
    logic pop;

    // card is addressed only with both match lines and qualifier
    assign sel = I_SELECT_MATCH_UPPER && I_SELECT_MATCH_LOWER
        && I_IO_INSTRUCTION_QUALIFIER;
    // acceptance high or line-ready low, or-tied
    assign hs_in = I_ACCEPT || !I_LINE_READY;
    // interrupt enable: flag, control and global enable
    assign ien_ok = s_q.flag && s_q.ctrl && I_GLOBAL_INTERRUPT_ENABLE;
    assign ack_p = (s_q.hs_ph == lpi_pkg::LPI_PH_ACK);
    // completion fires on the last cycle of the pulse window
    assign cmpl_p = (s_q.hs_ph == lpi_pkg::LPI_PH_CMPL) && (s_q.hs_cnt == 4'h0);
    assign fifo_in.ctrl = I_OUTPUT_BUS[`LPI_BIT_CTRL];
    assign fifo_in.data = I_OUTPUT_BUS[`LPI_DATA_W-1:0];
    // next word presented once the acknowledge window is over; popping inside
    // the window would lose a word, since the window keeps clearing loaded
    assign pop = fifo_valid && !s_q.loaded && !ack_p;

    // words queue here so the host may run ahead of the printer
    lpi_fifo #(.WIDTH($bits(lpi_pkg::lpi_word_t)), .DEPTH(`LPI_FIFO_DEPTH)) u_fifo (
        .i_clk(I_CLK),
        .i_rst(I_RST),
        .i_valid(sel && I_IO_OUTPUT_STROBE),
        .o_ready(fifo_ready),
        .i_data(fifo_in),
        .o_valid(fifo_valid),
        .i_ready(pop),
        .o_data(fifo_out)
    );

    // next-state logic
    always_comb begin
        s_d = s_q;
        s_d.hs_in_q = hs_in;
        s_d.crs_q = I_CONTROL_RESET_LINE;
        // handshake pulse sequencer: ack window then completion window
        case (s_q.hs_ph)
            lpi_pkg::LPI_PH_IDLE: begin
                if (hs_in && !s_q.hs_in_q) begin
                    s_d.hs_ph = lpi_pkg::LPI_PH_ACK;
                    s_d.hs_cnt = 4'(`LPI_ACK_CYCLES - 1);
                end
            end
            lpi_pkg::LPI_PH_ACK: begin
                if (s_q.hs_cnt == 4'h0) begin
                    s_d.hs_ph = lpi_pkg::LPI_PH_CMPL;
                    s_d.hs_cnt = 4'(`LPI_CMPL_CYCLES - 1);
                end else begin
                    s_d.hs_cnt = s_q.hs_cnt - 4'h1;
                end
            end
            lpi_pkg::LPI_PH_CMPL: begin
                if (s_q.hs_cnt == 4'h0) begin
                    s_d.hs_ph = lpi_pkg::LPI_PH_IDLE;
                end else begin
                    s_d.hs_cnt = s_q.hs_cnt - 4'h1;
                end
            end
            default: begin
                s_d.hs_ph = lpi_pkg::LPI_PH_IDLE;
            end
        endcase
        // flag set from a set buffer at T2; clear-flag wins afterwards
        if (I_FLAG_ENABLE_PULSE && s_q.flag_buf) begin
            s_d.flag = 1'b1;
        end
        if (sel && I_CLEAR_FLAG_INSTR) begin
            s_d.flag = 1'b0;
        end
        // buffer clears first so any set in the same cycle wins
        if ((sel && I_CLEAR_FLAG_INSTR) || I_INTERRUPT_ACKNOWLEDGE) begin
            s_d.flag_buf = 1'b0;
        end
        if (I_POWER_ON_PRESET_PULSE || (sel && I_SET_FLAG_INSTR) || cmpl_p) begin
            s_d.flag_buf = 1'b1;
        end
        // control pair; clear has priority as a reset
        if (sel && I_SET_CONTROL_INSTR) begin
            s_d.ctrl = 1'b1;
            s_d.strobe = 1'b1;
        end
        if (I_CONTROL_RESET_LINE || (sel && I_CLEAR_CONTROL_INSTR)) begin
            s_d.ctrl = 1'b0;
            s_d.strobe = 1'b0;
        end
        // acknowledge window drops the data-ready strobe
        if (ack_p) begin
            s_d.strobe = 1'b0;
            s_d.loaded = 1'b0;
        end
        // interrupt request: cleared at T2, set at T5
        if (I_FLAG_ENABLE_PULSE) begin
            s_d.irq = 1'b0;
        end
        if (I_SERVICE_REQUEST_STROBE && ien_ok && I_PRIORITY_IN_HIGH && s_q.flag_buf) begin
            s_d.irq = 1'b1;
        end
        // output word register, preset clears it
        if (pop) begin
            s_d.out_w = fifo_out;
            s_d.loaded = 1'b1;
        end
        if (I_POWER_ON_PRESET_PULSE) begin
            s_d.out_w = '0;
        end
        // master clear counter retriggered on control reset rise
        if (I_CONTROL_RESET_LINE && !s_q.crs_q) begin
            s_d.mclr_cnt = 10'(`LPI_MCLR_CYCLES);
        end else if (s_q.mclr_cnt != 10'h000) begin
            s_d.mclr_cnt = s_q.mclr_cnt - 10'h001;
        end
        // status word drives the bus only on a qualified input
        s_d.status = 16'h0000;
        if (sel && I_IO_INPUT_STROBE) begin
            s_d.status[`LPI_BIT_BUSY] = !hs_in;
            s_d.status[`LPI_BIT_PAPER] = I_PAPER_OUT;
            s_d.status[`LPI_BIT_READY] = I_READY;
        end
    end

    // single state register
    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // outputs
    assign O_PRIORITY_OUT_LOW = !(ien_ok && I_PRIORITY_IN_HIGH);
    assign O_FLAG_LINE_OUT = s_q.irq;
    assign O_INTERRUPT_REQUEST_OUT = s_q.irq;
    // skip path for the non-interrupt transfer method
    assign O_SKIP_FLAG_LINE = sel && ((I_SKIP_IF_FLAG_SET && s_q.flag)
        || (I_SKIP_IF_FLAG_CLEAR && !s_q.flag));
    assign O_INPUT_DATA_BUS = s_q.status;
    assign O_OUTPUT_WRITE_READY = fifo_ready;
    assign O_PRINT_DATA = s_q.out_w.data;
    assign O_CONTROL_BIT = s_q.out_w.ctrl;
    // strobe only once the word is in the output register
    assign O_DATA_READY = s_q.strobe && s_q.loaded;
    assign O_MASTER_CLEAR = (s_q.mclr_cnt != 10'h000);

    // request sets exactly one cycle after a qualifying T5
    property p_irq_set;
        @(posedge I_CLK) disable iff (I_RST)
        (I_SERVICE_REQUEST_STROBE && ien_ok && I_PRIORITY_IN_HIGH && s_q.flag_buf)
            |=> O_INTERRUPT_REQUEST_OUT;
    endproperty
    irq_set_a: assert property (p_irq_set) else $error("irq not set at T5");
    irq_clear_a: assert property (@(posedge I_CLK) disable iff (I_RST)
        (I_FLAG_ENABLE_PULSE && !I_SERVICE_REQUEST_STROBE) |=> !s_q.irq)
        else $error("irq not cleared at T2");
    flag_follow_a: assert property (@(posedge I_CLK) disable iff (I_RST)
        (I_FLAG_ENABLE_PULSE && s_q.flag_buf && !(sel && I_CLEAR_FLAG_INSTR)) |=> s_q.flag)
        else $error("flag not set at T2");
    clf_both_a: assert property (@(posedge I_CLK) disable iff (I_RST)
        (sel && I_CLEAR_FLAG_INSTR && !I_SET_FLAG_INSTR && !I_POWER_ON_PRESET_PULSE && !cmpl_p)
            |=> !s_q.flag && !s_q.flag_buf)
        else $error("clear-flag failed");
    preset_clr_a: assert property (@(posedge I_CLK) disable iff (I_RST)
        I_POWER_ON_PRESET_PULSE |=> (O_PRINT_DATA == 7'h00) && !O_CONTROL_BIT && s_q.flag_buf)
        else $error("preset did not clear output");
    mclr_len_a: assert property (@(posedge I_CLK) disable iff (I_RST)
        $rose(I_CONTROL_RESET_LINE) |=> O_MASTER_CLEAR [*8])
        else $error("master clear too short");
    ctrl_clear_a: assert property (@(posedge I_CLK) disable iff (I_RST)
        I_CONTROL_RESET_LINE |=> !s_q.ctrl && !O_DATA_READY)
        else $error("control reset failed");
    prio_out_a: assert property (@(posedge I_CLK) disable iff (I_RST)
        (s_q.flag && s_q.ctrl && I_GLOBAL_INTERRUPT_ENABLE && I_PRIORITY_IN_HIGH)
            |-> !O_PRIORITY_OUT_LOW)
        else $error("priority out not low");
    status_sel_a: assert property (@(posedge I_CLK) disable iff (I_RST)
        !sel |=> (O_INPUT_DATA_BUS == 16'h0000))
        else $error("status driven while unselected");
    ack_strobe_a: assert property (@(posedge I_CLK) disable iff (I_RST)
        (s_q.hs_ph == lpi_pkg::LPI_PH_ACK) |=> !O_DATA_READY)
        else $error("strobe not cleared by acknowledge");
    // every set source of the flag buffer takes effect on the next edge
    buf_set_a: assert property (@(posedge I_CLK) disable iff (I_RST)
        (I_POWER_ON_PRESET_PULSE || (sel && I_SET_FLAG_INSTR) || cmpl_p) |=> s_q.flag_buf)
        else $error("flag buffer not set");
    // acknowledge alone clears the buffer when no set competes
    buf_ack_a: assert property (@(posedge I_CLK) disable iff (I_RST)
        (I_INTERRUPT_ACKNOWLEDGE && !I_POWER_ON_PRESET_PULSE && !(sel && I_SET_FLAG_INSTR)
            && !cmpl_p) |=> !s_q.flag_buf)
        else $error("acknowledge did not clear buffer");
    // set-control raises control unless a clear competes
    ctrl_set_a: assert property (@(posedge I_CLK) disable iff (I_RST)
        (sel && I_SET_CONTROL_INSTR && !I_CLEAR_CONTROL_INSTR && !I_CONTROL_RESET_LINE)
            |=> s_q.ctrl)
        else $error("control not set");
    // no priority in means the chain is passed on untouched
    prio_high_a: assert property (@(posedge I_CLK) disable iff (I_RST)
        !I_PRIORITY_IN_HIGH |-> O_PRIORITY_OUT_LOW)
        else $error("priority out low without priority in");
    // both computer lines follow the request flip-flop
    irq_lines_a: assert property (@(posedge I_CLK) disable iff (I_RST)
        s_q.irq |-> O_FLAG_LINE_OUT && O_INTERRUPT_REQUEST_OUT)
        else $error("request lines not driven");
    // skip test on a set flag answers high
    skip_set_a: assert property (@(posedge I_CLK) disable iff (I_RST)
        (sel && I_SKIP_IF_FLAG_SET && s_q.flag) |-> O_SKIP_FLAG_LINE)
        else $error("skip line low with flag set");
    // an unaddressed card never answers a skip test
    skip_quiet_a: assert property (@(posedge I_CLK) disable iff (I_RST)
        !sel |-> !O_SKIP_FLAG_LINE)
        else $error("skip line driven while unselected");
    // the read status word carries the three printer indications
    status_read_a: assert property (@(posedge I_CLK) disable iff (I_RST)
        (sel && I_IO_INPUT_STROBE) |=> (O_INPUT_DATA_BUS[`LPI_BIT_READY] == $past(I_READY))
            && (O_INPUT_DATA_BUS[`LPI_BIT_PAPER] == $past(I_PAPER_OUT))
            && (O_INPUT_DATA_BUS[`LPI_BIT_BUSY] == !$past(hs_in)))
        else $error("status word wrong");
    // acknowledge window is a fixed four cycles
    ack_len_a: assert property (@(posedge I_CLK) disable iff (I_RST)
        $rose(ack_p) |-> ack_p [*4] ##1 !ack_p)
        else $error("acknowledge window length wrong");
    // completion at the end of both windows sets the buffer
    cmpl_flag_a: assert property (@(posedge I_CLK) disable iff (I_RST)
        $rose(ack_p) |-> ##8 s_q.flag_buf)
        else $error("completion did not set buffer");
    // no word is taken from the queue inside the acknowledge window
    ack_unload_a: assert property (@(posedge I_CLK) disable iff (I_RST)
        ack_p |=> !s_q.loaded)
        else $error("word loaded during acknowledge");
    // a popped word reaches the printer lines unchanged
    word_load_a: assert property (@(posedge I_CLK) disable iff (I_RST)
        (pop && !I_POWER_ON_PRESET_PULSE)
            |=> ({O_CONTROL_BIT, O_PRINT_DATA} == $past(fifo_out)))
        else $error("output word not loaded");
endmodule
`default_nettype wire

// file: design/lpi_defines.svh
`ifndef LPI_DEFINES_SVH
`define LPI_DEFINES_SVH
`define LPI_CLK_PERIOD_NS 8
`define LPI_MCLR_TIME_NS 5000
// least time rounds up, plus one cycle so it is strictly longer
`define LPI_MCLR_CYCLES ((`LPI_MCLR_TIME_NS + `LPI_CLK_PERIOD_NS - 1) / `LPI_CLK_PERIOD_NS + 1)
`define LPI_ACK_CYCLES 4
`define LPI_CMPL_CYCLES 4
`define LPI_BIT_BUSY 0
`define LPI_BIT_PAPER 14
`define LPI_BIT_READY 15
`define LPI_BIT_CTRL 15
`define LPI_DATA_W 7
`define LPI_FIFO_DEPTH 16
`define LPI_WORD_ZERO 8'h00
`endif

// file: design/lpi_pkg.sv
`default_nettype none
package lpi_pkg;
    typedef struct packed {
        logic ctrl;
        logic [6:0] data;
    } lpi_word_t;
    typedef enum logic [1:0] {
        LPI_PH_IDLE = 2'b00,
        LPI_PH_ACK = 2'b01,
        LPI_PH_CMPL = 2'b10
    } lpi_hs_t;
endpackage
`default_nettype wire

// file: design/lpi_fifo.sv
`include "lpi_defines.svh"
`default_nettype none
module lpi_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_valid,
    output logic o_ready,
    input wire logic [WIDTH-1:0] i_data,
    output logic o_valid,
    input wire logic i_ready,
    output logic [WIDTH-1:0] o_data
);
    localparam int AW = $clog2(DEPTH);
    // storage array, pointers one bit wider for full/empty
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wp_q;
    logic [AW:0] rp_q;
    logic full;
    logic empty;
    logic wr;
    logic rd;
    assign empty = (wp_q == rp_q);
    assign full = (wp_q[AW] != rp_q[AW]) && (wp_q[AW-1:0] == rp_q[AW-1:0]);
    assign o_ready = !full;
    assign o_valid = !empty;
    assign wr = i_valid && !full;
    assign rd = i_ready && !empty;
    // head word read straight from the array
    assign o_data = mem[rp_q[AW-1:0]];
    // pointer update
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            wp_q <= '0;
            rp_q <= '0;
        end else begin
            if (wr) begin
                wp_q <= wp_q + 1'b1;
            end
            if (rd) begin
                rp_q <= rp_q + 1'b1;
            end
        end
    end
    // memory write, no reset needed
    always_ff @(posedge i_clk) begin
        if (wr) begin
            mem[wp_q[AW-1:0]] <= i_data;
        end
    end
endmodule
`default_nettype wire

// file: tb/lpi_printer_model.sv
`default_nettype none
// behavioural printer: answers each data-ready strobe with an acceptance pulse
module lpi_printer_model (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_data_ready,
    input wire logic i_slow,
    input wire logic i_line_busy,
    output logic o_accept,
    output logic o_line_ready
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] st_q; // idle, delay, accepting, wait strobe drop
    logic [5:0] cnt_q; // delay and pulse length count
    // line-ready low while the bench holds i_line_busy high
    assign o_line_ready = !i_line_busy;
    assign o_accept = (st_q == 2'h2);
    // one acceptance per strobe; slow mode stalls the card on purpose
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            st_q <= 2'h0;
            cnt_q <= 6'h00;
        end else begin
            case (st_q)
                2'h0: if (i_data_ready) begin
                    st_q <= 2'h1;
                    cnt_q <= i_slow ? 6'h1E : 6'h03;
                end
                2'h1: if (cnt_q == 6'h00) begin
                    st_q <= 2'h2;
                    cnt_q <= 6'h01;
                end else cnt_q <= cnt_q - 6'h01;
                2'h2: if (cnt_q == 6'h00) st_q <= 2'h3;
                    else cnt_q <= cnt_q - 6'h01;
                default: if (!i_data_ready) st_q <= 2'h0; // re-arm only after strobe drops
            endcase
        end
    end
endmodule
`default_nettype wire

// file: tb/lpi_top_tb.sv
`default_nettype none
module lpi_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    // one-hot strobes for pulse()
    localparam logic [10:0] K_SETF = 11'h001, K_CLRF = 11'h002, K_SETC = 11'h004;
    localparam logic [10:0] K_CLRC = 11'h008, K_WR = 11'h010, K_RD = 11'h020;
    localparam logic [10:0] K_PRE = 11'h040, K_CRL = 11'h080, K_T2 = 11'h100;
    localparam logic [10:0] K_ACK = 11'h200, K_T5 = 11'h400;
    logic I_CLK, I_RST, I_GLOBAL_INTERRUPT_ENABLE, I_PRIORITY_IN_HIGH, I_READY, I_PAPER_OUT;
    logic I_SKIP_IF_FLAG_SET, I_SKIP_IF_FLAG_CLEAR, slow, line_busy;
    logic [15:0] I_OUTPUT_BUS;
    logic [10:0] p; // pulsed strobes
    logic [2:0] sel; // select lines and qualifier
    wire logic I_SET_FLAG_INSTR, I_CLEAR_FLAG_INSTR, I_SET_CONTROL_INSTR, I_CLEAR_CONTROL_INSTR;
    wire logic I_IO_OUTPUT_STROBE, I_IO_INPUT_STROBE, I_POWER_ON_PRESET_PULSE;
    wire logic I_CONTROL_RESET_LINE, I_FLAG_ENABLE_PULSE, I_INTERRUPT_ACKNOWLEDGE;
    wire logic I_SERVICE_REQUEST_STROBE, I_SELECT_MATCH_UPPER, I_SELECT_MATCH_LOWER;
    wire logic I_IO_INSTRUCTION_QUALIFIER, I_ACCEPT, I_LINE_READY;
    logic O_PRIORITY_OUT_LOW, O_FLAG_LINE_OUT, O_INTERRUPT_REQUEST_OUT, O_SKIP_FLAG_LINE;
    logic O_OUTPUT_WRITE_READY, O_CONTROL_BIT, O_DATA_READY, O_MASTER_CLEAR;
    logic [15:0] O_INPUT_DATA_BUS;
    logic [6:0] O_PRINT_DATA;
    int num_errors = 0, comparisons = 0, n;
    assign {I_SERVICE_REQUEST_STROBE, I_INTERRUPT_ACKNOWLEDGE, I_FLAG_ENABLE_PULSE,
        I_CONTROL_RESET_LINE, I_POWER_ON_PRESET_PULSE, I_IO_INPUT_STROBE, I_IO_OUTPUT_STROBE,
        I_CLEAR_CONTROL_INSTR, I_SET_CONTROL_INSTR, I_CLEAR_FLAG_INSTR, I_SET_FLAG_INSTR} = p;
    assign {I_SELECT_MATCH_UPPER, I_SELECT_MATCH_LOWER, I_IO_INSTRUCTION_QUALIFIER} = sel;
    lpi_top DUT (.I_CLK, .I_RST, .I_POWER_ON_PRESET_PULSE, .I_CONTROL_RESET_LINE,
        .I_FLAG_ENABLE_PULSE, .I_INTERRUPT_ACKNOWLEDGE, .I_SERVICE_REQUEST_STROBE,
        .I_SELECT_MATCH_UPPER, .I_SELECT_MATCH_LOWER, .I_IO_INSTRUCTION_QUALIFIER,
        .I_SET_FLAG_INSTR, .I_CLEAR_FLAG_INSTR, .I_SET_CONTROL_INSTR, .I_CLEAR_CONTROL_INSTR,
        .I_GLOBAL_INTERRUPT_ENABLE, .I_PRIORITY_IN_HIGH, .I_IO_OUTPUT_STROBE, .I_IO_INPUT_STROBE,
        .I_SKIP_IF_FLAG_SET, .I_SKIP_IF_FLAG_CLEAR, .I_OUTPUT_BUS, .I_ACCEPT, .I_LINE_READY,
        .I_READY, .I_PAPER_OUT, .O_PRIORITY_OUT_LOW, .O_FLAG_LINE_OUT, .O_INTERRUPT_REQUEST_OUT,
        .O_SKIP_FLAG_LINE, .O_INPUT_DATA_BUS, .O_OUTPUT_WRITE_READY, .O_PRINT_DATA,
        .O_CONTROL_BIT, .O_DATA_READY, .O_MASTER_CLEAR);
    lpi_printer_model printer (.i_clk(I_CLK), .i_rst(I_RST), .i_data_ready(O_DATA_READY),
        .i_slow(slow), .i_line_busy(line_busy), .o_accept(I_ACCEPT), .o_line_ready(I_LINE_READY));
    // free-running clock, 8 ns
    initial begin
        I_CLK = 1'b0;
        forever #4 I_CLK = ~I_CLK;
    end
    task automatic report_and_stop;
        $display("errors %0d, checks %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    // one-cycle strobe, then settle to the following falling edge
    task automatic pulse(input logic [10:0] v);
        @(posedge I_CLK) p <= v;
        @(posedge I_CLK) p <= 11'h000;
        @(negedge I_CLK);
    endtask
    // skip line through both skip tests; flag state seen only this way
    task automatic flag_is(input logic exp);
        @(posedge I_CLK) I_SKIP_IF_FLAG_SET <= 1'b1;
        @(negedge I_CLK) chk(16'(O_SKIP_FLAG_LINE), 16'(exp));
        @(posedge I_CLK) {I_SKIP_IF_FLAG_SET, I_SKIP_IF_FLAG_CLEAR} <= 2'b01;
        @(negedge I_CLK) chk(16'(O_SKIP_FLAG_LINE), 16'(!exp));
        @(posedge I_CLK) I_SKIP_IF_FLAG_CLEAR <= 1'b0;
    endtask
    // bounded wait on the data-ready strobe
    task automatic wait_dr(input logic lvl);
        int k;
        k = 0;
        while (O_DATA_READY !== lvl && k < 200) begin
            @(negedge I_CLK);
            k++;
        end
        chk(16'(k < 200), 16'h0001);
    endtask
    task automatic send(input logic [15:0] w);
        @(posedge I_CLK) I_OUTPUT_BUS <= w;
        pulse(K_WR);
    endtask
    // strobe the held word out and let both handshake windows finish
    task automatic xfer(input logic [7:0] exp);
        pulse(K_SETC);
        wait_dr(1'b1);
        chk(16'({O_CONTROL_BIT, O_PRINT_DATA}), 16'(exp));
        wait_dr(1'b0);
        repeat (12) @(negedge I_CLK);
    endtask
    // watchdog well past the expected run of under two thousand cycles
    initial begin
        #400000;
        num_errors++;
        report_and_stop();
    end
    initial begin
        {p, I_RST, I_GLOBAL_INTERRUPT_ENABLE, I_PRIORITY_IN_HIGH, I_READY, I_PAPER_OUT} = '0;
        {I_SKIP_IF_FLAG_SET, I_SKIP_IF_FLAG_CLEAR, slow, line_busy, I_OUTPUT_BUS} = '0;
        sel = 3'b111;
        I_RST = 1'b1;
        repeat (12) @(posedge I_CLK);
        I_RST <= 1'b0;
        @(negedge I_CLK) chk(16'({O_PRIORITY_OUT_LOW, O_MASTER_CLEAR}), 16'h0002);
        pulse(K_PRE);
        flag_is(1'b0);
        pulse(K_T2);
        flag_is(1'b1);
        pulse(K_CLRF);
        pulse(K_T2);
        flag_is(1'b0);
        @(posedge I_CLK) sel <= 3'b110; // qualifier missing
        pulse(K_SETF);
        @(posedge I_CLK) sel <= 3'b111;
        pulse(K_T2);
        flag_is(1'b0);
        pulse(K_SETF);
        pulse(K_T2);
        flag_is(1'b1);
        pulse(K_CLRF);
        send(16'h8041);
        xfer(8'hC1);
        pulse(K_T2);
        flag_is(1'b1);
        pulse(K_PRE);
        chk(16'({O_CONTROL_BIT, O_PRINT_DATA}), 16'h0000);
        // interrupt chain: enable, priority, repeat request
        // control is still set by the transfer above, so clear it first
        pulse(K_CLRC);
        @(posedge I_CLK) {I_GLOBAL_INTERRUPT_ENABLE, I_PRIORITY_IN_HIGH} <= 2'b11;
        @(negedge I_CLK) chk(16'(O_PRIORITY_OUT_LOW), 16'h0001);
        pulse(K_SETC);
        chk(16'(O_PRIORITY_OUT_LOW), 16'h0000);
        pulse(K_T5);
        chk(16'({O_FLAG_LINE_OUT, O_INTERRUPT_REQUEST_OUT}), 16'h0003);
        pulse(K_T2);
        chk(16'(O_INTERRUPT_REQUEST_OUT), 16'h0000);
        pulse(K_T5);
        chk(16'(O_INTERRUPT_REQUEST_OUT), 16'h0001);
        pulse(K_T2);
        @(posedge I_CLK) I_PRIORITY_IN_HIGH <= 1'b0;
        pulse(K_T5);
        chk(16'({O_PRIORITY_OUT_LOW, O_INTERRUPT_REQUEST_OUT}), 16'h0002);
        @(posedge I_CLK) {I_GLOBAL_INTERRUPT_ENABLE, I_PRIORITY_IN_HIGH} <= 2'b01;
        pulse(K_T5);
        chk(16'(O_INTERRUPT_REQUEST_OUT), 16'h0000);
        @(posedge I_CLK) I_GLOBAL_INTERRUPT_ENABLE <= 1'b1;
        pulse(K_ACK);
        pulse(K_T5);
        chk(16'(O_INTERRUPT_REQUEST_OUT), 16'h0000);
        // status word, every ready and paper combination
        for (int i = 0; i < 4; i++) begin
            @(posedge I_CLK) {I_READY, I_PAPER_OUT} <= 2'(i);
            pulse(K_RD);
            chk(O_INPUT_DATA_BUS, {2'(i), 14'h0001});
        end
        @(posedge I_CLK) line_busy <= 1'b1;
        pulse(K_RD);
        chk(O_INPUT_DATA_BUS, 16'hC000);
        @(posedge I_CLK) sel <= 3'b011;
        pulse(K_RD);
        chk(O_INPUT_DATA_BUS, 16'h0000);
        @(posedge I_CLK) {sel, line_busy} <= 4'hE;
        pulse(K_CLRC);
        chk(16'(O_PRIORITY_OUT_LOW), 16'h0001);
        pulse(K_SETC);
        pulse(K_CRL);
        chk(16'(O_PRIORITY_OUT_LOW), 16'h0001);
        repeat (2) if (O_MASTER_CLEAR !== 1'b1) @(negedge I_CLK);
        n = 0;
        while (O_MASTER_CLEAR === 1'b1 && n < 2000) begin
            @(negedge I_CLK);
            n++;
        end
        chk(16'(n), 16'd626);
        // fill until refused, then drain against a stalling printer
        slow <= 1'b1;
        n = 0;
        while (O_OUTPUT_WRITE_READY === 1'b1 && n < 40) begin
            send(16'(n + 32));
            n++;
        end
        chk(16'(n), 16'd17);
        for (int i = 0; i < 17; i++) xfer(8'(i + 32));
        chk(16'(O_OUTPUT_WRITE_READY), 16'h0001);
        report_and_stop();
    end
endmodule
`default_nettype wire
